/* File: rxc_checksum.sv */
// Receive ICMP/ICMPv6/IGMP checksum checker with raw layer-3 sum
// Contract
// - IPv4 protocol 1 marks ICMP
// - ICMP sum over message, no pseudo-header
// - IPv6 next header 58 marks ICMPv6
// - ICMPv6 sum adds pseudo-header with 58
// - ICMP checks only while ICMP enable set
// - Fragments skip ICMP check
// - IPv4 protocol 2 marks IGMP
// - IGMP sum covers whole IP payload
// - IGMP checks only while IGMP enable set
// - Fragments skip IGMP, raw sum kept
// - IPv6 in IPv4: ICMP yes, IGMP no
// - IPv4 in IPv4: no checks, raw only
// - Non-IP layer 3: raw sum only
// - Other layer 4: raw sum still produced
// - Skip hop, destination, routing headers; fragment unsupported
// - Fragment: MF with zero offset, or offset
// - Check passes only when sum is FFFF
// - Failed check sets upper-layer error bit
// - Raw layer-3 sum goes in status
`timescale 1ns/1ps
`default_nettype none
`include "rxc_params.svh"
module rxc_checksum (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Frame bytes from the MAC receive path, FCS already removed
  input wire rxc_pkg::rxc_byte_type rx,
  // Per-frame status to the receive FIFO controller
  output rxc_pkg::rxc_sts_type sts,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // One's complement add with end-around carry
  function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'h0, a} + {1'h0, b};
    oc_add = s[15:0] + {15'h0000, s[16]};
  endfunction

  // Place a byte in the high or low half of a 16-bit word
  function automatic logic [15:0] term(input logic [7:0] d, input logic hi);
    term = hi ? {d, 8'h00} : {8'h00, d};
  endfunction

  // IPv6 next header dispatch after a fixed or extension header
  function automatic rxc_pkg::rxc_state_type v6_next(input logic [7:0] nh);
    if (nh == `RXC_PROTO_ICMPV6) begin
      v6_next = rxc_pkg::ST_L4;
    end else if (nh == `RXC_NH_HOP || nh == `RXC_NH_ROUTE || nh == `RXC_NH_DEST) begin
      v6_next = rxc_pkg::ST_EXT;
    end else begin
      v6_next = rxc_pkg::ST_RAW; // Fragment header and others
    end
  endfunction

  rxc_pkg::rxc_state_type st, next_st;
  rxc_pkg::rxc_kind_type kind, next_kind;
  logic [15:0] cnt, next_cnt;
  logic [1:0] vcnt, next_vcnt;
  logic [7:0] hold, next_hold;
  logic [15:0] raw, next_raw;
  logic l3_hi, next_l3_hi;
  logic [15:0] l4, next_l4;
  logic [15:0] rem, next_rem;
  logic [15:0] plen6, next_plen6;
  logic [15:0] hlen, next_hlen;
  logic [7:0] proto, next_proto;
  logic mf, next_mf;
  logic frag, next_frag;
  logic tun, next_tun;
  rxc_pkg::rxc_sts_type next_sts;
  logic icmp_en, next_icmp_en;
  logic igmp_en, next_igmp_en;
  logic [15:0] last_raw, next_last_raw;
  logic last_err, next_last_err;
  logic [31:0] next_rdata;
  logic next_wait;

  // Parser and summers
  always_comb begin
    rxc_pkg::rxc_state_type cs;
    logic [15:0] cc;
    logic [15:0] fin;
    logic chk;
    logic [7:0] d;
    cs = rx.sof ? rxc_pkg::ST_MAC : st;
    cc = rx.sof ? 16'h0000 : cnt;
    fin = 16'h0000;
    chk = 1'b0;
    d = rx.data;
    next_st = st;
    next_kind = rx.sof ? rxc_pkg::K_NONE : kind;
    next_cnt = cc + 16'h0001;
    next_vcnt = rx.sof ? 2'h0 : vcnt;
    next_hold = hold;
    next_raw = rx.sof ? 16'h0000 : raw;
    next_l3_hi = rx.sof ? 1'b0 : l3_hi;
    next_l4 = rx.sof ? 16'h0000 : l4;
    next_rem = rem;
    next_plen6 = plen6;
    next_hlen = hlen;
    next_proto = proto;
    next_mf = mf;
    next_frag = rx.sof ? 1'b0 : frag;
    next_tun = rx.sof ? 1'b0 : tun;
    next_sts = '0;
    if (rx.valid && cs != rxc_pkg::ST_IDLE) begin
      next_st = cs;
      // Raw sum over every byte after the type field; low byte first
      if (cs != rxc_pkg::ST_MAC) begin
        next_raw = oc_add(next_raw, term(d, next_l3_hi));
        next_l3_hi = ~next_l3_hi;
      end
      case (cs)
        rxc_pkg::ST_MAC: begin
          if (cc == `RXC_TYPE_HI_POS) begin
            next_hold = d;
          end
          if (cc == `RXC_TYPE_LO_POS) begin
            // Rewinding the counter reuses the type decode after a tag
            if ({hold, d} == `RXC_VLAN_TYPE && vcnt != `RXC_MAX_VLAN) begin
              next_vcnt = vcnt + 2'h1;
              next_cnt = `RXC_VLAN_REWIND;
            end else if ({hold, d} < `RXC_SNAP_LIMIT) begin
              next_cnt = `RXC_SNAP_REWIND;
            end else begin
              next_cnt = 16'h0000;
              if ({hold, d} == `RXC_ETH_IPV4) begin
                next_st = rxc_pkg::ST_IP4;
              end else if ({hold, d} == `RXC_ETH_IPV6) begin
                next_st = rxc_pkg::ST_IP6;
              end else begin
                next_st = rxc_pkg::ST_RAW;
              end
            end
          end
        end
        rxc_pkg::ST_IP4: begin
          if (cc == 16'h0000) begin
            next_hlen = {10'h000, d[3:0], 2'h0};
            if (d[7:4] != `RXC_IP4_VERSION || d[3:0] < `RXC_IP4_MIN_IHL) begin
              next_st = rxc_pkg::ST_RAW;
            end
          end
          if (cc == `RXC_IP4_TLEN_HI) begin
            next_rem[15:8] = d;
          end
          if (cc == `RXC_IP4_TLEN_LO) begin
            next_rem[7:0] = d;
          end
          if (cc == `RXC_IP4_FRAG_HI) begin
            next_mf = d[`RXC_IP4_MF_BIT];
            next_hold = {3'h0, d[4:0]};
          end
          if (cc == `RXC_IP4_FRAG_LO) begin
            next_frag = mf || ({hold[4:0], d} != 13'h0000);
          end
          if (cc == `RXC_IP4_PROTO) begin
            next_proto = d;
          end
          if (cc == hlen - 16'h0001 && cc > `RXC_IP4_PROTO) begin
            next_cnt = 16'h0000;
            next_rem = rem - hlen;
            next_st = rxc_pkg::ST_RAW; // Other protocols
            if (!frag) begin
              if (proto == `RXC_PROTO_ICMP) begin
                next_kind = rxc_pkg::K_ICMP4;
                next_st = rxc_pkg::ST_L4;
              end else if (proto == `RXC_PROTO_IGMP) begin
                next_kind = rxc_pkg::K_IGMP;
                next_st = rxc_pkg::ST_L4;
              end else if (proto == `RXC_PROTO_IPV6) begin
                next_tun = 1'b1;
                next_st = rxc_pkg::ST_IP6;
              end
            end
            if (proto == `RXC_PROTO_IPIP) begin
              next_st = rxc_pkg::ST_RAW;
            end
          end
        end
        rxc_pkg::ST_IP6: begin
          if (cc == `RXC_IP6_PLEN_HI) begin
            next_rem[15:8] = d;
          end
          if (cc == `RXC_IP6_PLEN_LO) begin
            next_rem[7:0] = d;
          end
          if (cc == `RXC_IP6_NH) begin
            next_proto = d;
          end
          // Addresses feed the pseudo-header part of the sum
          if (cc >= `RXC_IP6_ADDR_FIRST) begin
            next_l4 = oc_add(next_l4, term(d, ~cc[0]));
          end
          if (cc == `RXC_IP6_HDR_LAST) begin
            next_cnt = 16'h0000;
            next_st = v6_next(proto);
            next_plen6 = rem;
            if (next_st == rxc_pkg::ST_L4) begin
              next_kind = rxc_pkg::K_ICMP6;
            end
          end
        end
        rxc_pkg::ST_EXT: begin
          if (cc == `RXC_EXT_NH) begin
            next_proto = d;
          end
          if (cc == `RXC_EXT_LEN) begin
            next_hlen = {5'h00, d, 3'h0} + 16'h0008;
          end
          if (cc > `RXC_EXT_LEN && cc == hlen - 16'h0001) begin
            next_cnt = 16'h0000;
            next_rem = rem - hlen;
            next_plen6 = rem - hlen;
            next_st = v6_next(proto);
            if (next_st == rxc_pkg::ST_L4) begin
              next_kind = rxc_pkg::K_ICMP6;
            end
          end
        end
        rxc_pkg::ST_L4: begin
          // Message bytes only, padding beyond the IP length excluded
          if (rem != 16'h0000) begin
            next_l4 = oc_add(next_l4, term(d, ~cc[0]));
            next_rem = rem - 16'h0001;
          end
        end
        default: begin
          next_cnt = cc;
        end
      endcase
      // Status built from this cycle's totals, so it always matches its frame
      if (rx.eof) begin
        next_st = rxc_pkg::ST_IDLE;
        fin = next_l4;
        if (next_kind == rxc_pkg::K_ICMP6) begin
          fin = oc_add(oc_add(fin, next_plen6), {8'h00, `RXC_PROTO_ICMPV6});
        end
        case (next_kind)
          rxc_pkg::K_ICMP4, rxc_pkg::K_ICMP6: chk = icmp_en;
          rxc_pkg::K_IGMP: chk = igmp_en && !next_tun;
          default: chk = 1'b0;
        endcase
        next_sts.valid = 1'b1;
        next_sts.raw_sum = next_raw;
        // Truncated message counts as a failure
        next_sts.l4_err = chk && (fin != `RXC_SUM_OK || next_rem != 16'h0000 ||
          next_st == rxc_pkg::ST_L4 && next_rem != 16'h0000);
      end
    end
  end

  // Avalon slave: one wait cycle, then accept; unmapped reads zero
  always_comb begin
    next_icmp_en = icmp_en;
    next_igmp_en = igmp_en;
    next_last_raw = sts.valid ? sts.raw_sum : last_raw;
    next_last_err = sts.valid ? sts.l4_err : last_err;
    next_wait = ~((avs_read || avs_write) && avs_waitrequest);
    next_rdata = avs_readdata;
    if ((avs_read || avs_write) && avs_waitrequest) begin
      next_rdata = 32'h0000_0000;
      if (avs_address == `RXC_CTRL_OFS) begin
        next_rdata[`RXC_ICMP_EN_BIT] = icmp_en;
        next_rdata[`RXC_IGMP_EN_BIT] = igmp_en;
      end else if (avs_address == `RXC_STAT_OFS) begin
        next_rdata[15:0] = next_last_raw;
        next_rdata[`RXC_ERR_BIT] = next_last_err;
      end
    end
    if (avs_write && !avs_waitrequest && avs_address == `RXC_CTRL_OFS && avs_byteenable[0]) begin
      next_icmp_en = avs_writedata[`RXC_ICMP_EN_BIT];
      next_igmp_en = avs_writedata[`RXC_IGMP_EN_BIT];
    end
  end

  // State registers; clock enable freezes everything
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= rxc_pkg::ST_IDLE;
      kind <= rxc_pkg::K_NONE;
      cnt <= '0;
      vcnt <= '0;
      hold <= '0;
      raw <= '0;
      l3_hi <= 1'b0;
      l4 <= '0;
      rem <= '0;
      plen6 <= '0;
      hlen <= '0;
      proto <= '0;
      mf <= 1'b0;
      frag <= 1'b0;
      tun <= 1'b0;
      sts <= '0;
      icmp_en <= 1'b0;
      igmp_en <= 1'b0;
      last_raw <= '0;
      last_err <= 1'b0;
      avs_readdata <= '0;
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      st <= next_st;
      kind <= next_kind;
      cnt <= next_cnt;
      vcnt <= next_vcnt;
      hold <= next_hold;
      raw <= next_raw;
      l3_hi <= next_l3_hi;
      l4 <= next_l4;
      rem <= next_rem;
      plen6 <= next_plen6;
      hlen <= next_hlen;
      proto <= next_proto;
      mf <= next_mf;
      frag <= next_frag;
      tun <= next_tun;
      sts <= next_sts;
      icmp_en <= next_icmp_en;
      igmp_en <= next_igmp_en;
      last_raw <= next_last_raw;
      last_err <= next_last_err;
      avs_readdata <= next_rdata;
      avs_waitrequest <= next_wait;
    end
  end
endmodule
`default_nettype wire

/* File: rxc_checksum_properties.sv */
// Port-level assertions for the receive checksum checker
`timescale 1ns/1ps
`default_nettype none
module rxc_checksum_properties (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Stream and status
  input wire rxc_pkg::rxc_byte_type rx,
  input wire rxc_pkg::rxc_sts_type sts,
  // Register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  logic [1:0] en, next_en;
  logic [16:0] last, next_last;
  logic rd_done, eof_take;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  assign rd_done = ce && avs_read && !avs_waitrequest;
  assign eof_take = ce && rx.valid && rx.eof;
  // Shadows of the enables and last status, as software should see them
  always_comb begin
    next_en = en;
    next_last = last;
    if (ce && avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0]) begin
      next_en = avs_writedata[1:0];
    end
    if (ce && sts.valid) begin
      next_last = {sts.l4_err, sts.raw_sum};
    end
    if (srst) begin
      next_en = 2'h0;
      next_last = 17'h0_0000;
    end
  end
  always_ff @(posedge clk) begin
    en <= next_en;
    last <= next_last;
  end
  // Status timing against the last byte of a frame
  AST_STS_AFTER_EOF: assert property (eof_take |=> sts.valid) else $error("no status");
  AST_STS_CAUSE: assert property (sts.valid |-> $past(eof_take)) else $error("stray status");
  AST_NO_ERR_OFF: assert property (sts.valid && en == 2'h0 |-> !sts.l4_err) else $error("err off");
  // Bus handshake: one wait cycle, then a single ready cycle
  AST_WAIT_ONE: assert property (ce && (avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("late answer");
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long ready");
  AST_WAIT_IDLE: assert property (ce && !avs_read && !avs_write |=> avs_waitrequest)
    else $error("ready when idle");
  // Read data against the shadows; stale status would show here
  AST_STAT_READ: assert property (rd_done && avs_address == 4'h4 |-> avs_readdata == {15'h0000, last}) else $error("stat");
  AST_CTRL_READ: assert property (rd_done && avs_address == 4'h0 |-> avs_readdata[1:0] == en) else $error("ctrl");
  AST_UNMAPPED: assert property (rd_done && avs_address != 4'h0 && avs_address != 4'h4
    |-> avs_readdata == 32'h0000_0000) else $error("unmapped");
  // Main scenarios
  COV_ERR: cover property (sts.valid && sts.l4_err);
  COV_PASS: cover property (sts.valid && !sts.l4_err && en != 2'h0);
  COV_STAT: cover property (rd_done && avs_address == 4'h4);
endmodule
`default_nettype wire

/* File: rxc_checksum_tb.sv */
// Self-checking bench for the receive checksum checker
`timescale 1ns/1ps
`default_nettype none
module rxc_checksum_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  int l3 = 14;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest;
  rxc_pkg::rxc_byte_type rx;
  rxc_pkg::rxc_sts_type sts;
  int bad_count = 0;
  int compares = 0;
  logic [7:0] f[$];
  // 100 MHz clock
  always #5 clk = ~clk;
  rxc_checksum rxc_checksum_i (.clk(clk), .srst(srst), .ce(ce), .rx(rx), .sts(sts),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  rxc_mac_model rxc_mac_model_i (.clk(clk), .rx(rx), .sts(sts));
  task automatic wrap_up();
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One access; request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] be,
    input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20) begin
      bad_count++;
      wrap_up();
    end
  endtask
  // One's complement sum; sw puts the first byte of each pair low
  function automatic logic [15:0] ocs(input logic [7:0] b[$], input int s, input int e,
    input bit sw, input logic [15:0] acc);
    logic [16:0] t;
    logic [7:0] x;
    t = {1'b0, acc};
    for (int i = s; i < e; i += 2) begin
      x = (i + 1 < e) ? b[i+1] : 8'h00;
      t = t[15:0] + (sw ? {x, b[i]} : {b[i], x}) + t[16];
    end
    return t[15:0] + t[16];
  endfunction
  // Frame: MAC header, IPv4 or IPv6 header, n payload bytes with checksum at 2..3
  task automatic mk(input bit v6, input logic [7:0] pr, input logic [15:0] fr, input int n,
    input bit good);
    logic [7:0] pq[$];
    logic [15:0] c;
    int s;
    f = {};
    for (int i = 0; i < 12; i++) f.push_back(8'(i + 2));
    if (v6) begin
      f = {f, 8'h86, 8'hdd, 8'h60, 8'h00, 8'h00, 8'h00, 8'(n >> 8), 8'(n), pr, 8'h40};
      for (int i = 0; i < 32; i++) f.push_back(8'(i * 5));
    end else begin
      f = {f, 8'h08, 8'h00, 8'h45, 8'h00, 8'((n + 20) >> 8), 8'(n + 20), 8'h00, 8'h01,
        fr[15:8], fr[7:0], 8'h40, pr, 8'h00, 8'h00};
      for (int i = 0; i < 8; i++) f.push_back(8'(i + 9));
    end
    s = f.size();
    for (int i = 0; i < n; i++) f.push_back(8'(i * 7 + 3));
    f[s + 2] = 8'h00;
    f[s + 3] = 8'h00;
    pq = {8'(n >> 8), 8'(n), 8'h00, 8'h3a};
    c = v6 ? ocs(pq, 0, 4, 0, ocs(f, 22, 54, 0, 16'h0000)) : 16'h0000;
    c = ~ocs(f, s, s + n, 0, c);
    f[s + 2] = c[15:8];
    f[s + 3] = c[7:0] ^ {7'h00, !good};
  endtask
  // Send the frame, await its status, then read it back as STAT
  task automatic run(input logic err);
    int c;
    logic [31:0] e;
    c = rxc_mac_model_i.cnt;
    e = {15'h0000, err, ocs(f, l3, f.size(), 1, 16'h0000)};
    rxc_mac_model_i.send(f);
    for (int n = 0; n < 20 && rxc_mac_model_i.cnt == c; n++) @(posedge clk);
    if (rxc_mac_model_i.cnt == c) begin
      bad_count++;
      wrap_up();
    end else begin
      check({15'h0000, rxc_mac_model_i.got}, e);
      bus(1'b0, 4'h4, 4'hf, 32'h0000_0000);
      check(q, e);
    end
  endtask
  // Enables, their byte lane, unmapped space
  task automatic sc_regs();
    bus(1'b1, 4'h0, 4'hf, 32'h0000_0003);
    bus(1'b1, 4'h0, 4'he, 32'h0000_0000);
    bus(1'b1, 4'hc, 4'hf, 32'hffff_ffff);
    bus(1'b0, 4'h0, 4'hf, 32'h0000_0000);
    check({30'h0, q[1:0]}, 32'h0000_0003);
    bus(1'b0, 4'h8, 4'hf, 32'h0000_0000);
    check(q, 32'h0000_0000);
  endtask
  // Clock enable low freezes the slave; the held read completes once it returns
  task automatic sc_ce();
    ce <= 1'b0;
    fork
      bus(1'b0, 4'h0, 4'hf, 32'h0000_0000);
      begin
        repeat (4) @(posedge clk);
        check({31'h0, avs_waitrequest}, 32'h0000_0001);
        ce <= 1'b1;
      end
    join
    check(q, 32'h0000_0003);
  endtask
  // ICMP good, bad, first fragment, later fragment
  task automatic sc_icmp();
    mk(1'b0, 8'h01, 16'h0000, 9, 1'b1);
    run(1'b0);
    mk(1'b0, 8'h01, 16'h0000, 9, 1'b0);
    run(1'b1);
    mk(1'b0, 8'h01, 16'h2000, 9, 1'b0);
    run(1'b0);
    mk(1'b0, 8'h01, 16'h0001, 9, 1'b0);
    run(1'b0);
  endtask
  // ICMPv6 with pseudo-header, good then bad
  task automatic sc_icmp6();
    mk(1'b1, 8'h3a, 16'h0000, 12, 1'b1);
    run(1'b0);
    mk(1'b1, 8'h3a, 16'h0000, 12, 1'b0);
    run(1'b1);
  endtask
  // IGMP good, bad, fragment
  task automatic sc_igmp();
    mk(1'b0, 8'h02, 16'h0000, 8, 1'b1);
    run(1'b0);
    mk(1'b0, 8'h02, 16'h0000, 8, 1'b0);
    run(1'b1);
    mk(1'b0, 8'h02, 16'h2000, 8, 1'b0);
    run(1'b0);
  endtask
  // Each check switched off alone, then both; bad frames pass clean
  task automatic sc_off();
    bus(1'b1, 4'h0, 4'hf, 32'h0000_0001);
    mk(1'b0, 8'h02, 16'h0000, 8, 1'b0);
    run(1'b0);
    bus(1'b1, 4'h0, 4'hf, 32'h0000_0002);
    mk(1'b0, 8'h01, 16'h0000, 9, 1'b0);
    run(1'b0);
    mk(1'b1, 8'h3a, 16'h0000, 12, 1'b0);
    run(1'b0);
    bus(1'b1, 4'h0, 4'hf, 32'h0000_0000);
    mk(1'b0, 8'h01, 16'h0000, 9, 1'b0);
    run(1'b0);
    bus(1'b1, 4'h0, 4'hf, 32'h0000_0003);
  endtask
  // Tunnel, non-IP and other transport: raw sum only
  task automatic sc_other();
    mk(1'b0, 8'h04, 16'h0000, 20, 1'b0);
    run(1'b0);
    mk(1'b0, 8'h01, 16'h0000, 9, 1'b0);
    f[12] = 8'h88;
    f[13] = 8'hb5;
    run(1'b0);
    mk(1'b0, 8'h59, 16'h0000, 9, 1'b0);
    run(1'b0);
  endtask
  // Eight bytes of tags or SNAP header between source address and type
  task automatic put8(input logic [63:0] t);
    for (int i = 0; i < 8; i++) f.insert(12 + i, t[63 - 8 * i -: 8]);
  endtask
  // Carry the frame just built, less its MAC header, inside an outer IPv4 packet
  task automatic wrap4();
    logic [7:0] pq[$];
    for (int i = 14; i < f.size(); i++) pq.push_back(f[i]);
    mk(1'b0, 8'h29, 16'h0000, pq.size(), 1'b0);
    for (int i = 0; i < pq.size(); i++) f[34 + i] = pq[i];
  endtask
  // Extension headers, IPv6 in IPv4, stacked tags and SNAP framing
  task automatic sc_ext();
    for (int g = 0; g < 2; g++) begin
      mk(1'b1, 8'h00, 16'h0000, 12, g == 1);
      for (int i = 0; i < 8; i++) f.insert(54 + i, i == 0 ? 8'h3a : 8'h00);
      f[19] = 8'h14;
      run(g == 0);
    end
    mk(1'b1, 8'h2c, 16'h0000, 12, 1'b0);
    run(1'b0);
    mk(1'b1, 8'h3a, 16'h0000, 12, 1'b0);
    wrap4();
    run(1'b1);
    mk(1'b1, 8'h02, 16'h0000, 8, 1'b0);
    wrap4();
    run(1'b0);
    l3 = 22;
    mk(1'b0, 8'h01, 16'h0000, 9, 1'b0);
    put8(64'h8100_0005_8100_0006);
    run(1'b1);
    mk(1'b0, 8'h02, 16'h0000, 8, 1'b0);
    put8(64'h0040_aaaa_0300_0000);
    run(1'b1);
    l3 = 14;
  endtask
  // Reset in mid-run clears the enables and the last status
  task automatic sc_reset();
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, 4'h0, 4'hf, 32'h0000_0000);
    check(q, 32'h0000_0000);
    bus(1'b0, 4'h4, 4'hf, 32'h0000_0000);
    check(q, 32'h0000_0000);
  endtask
  // Reset for 16 cycles, then the scenarios
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    sc_regs();
    sc_ce();
    sc_icmp();
    sc_icmp6();
    sc_igmp();
    sc_off();
    sc_other();
    sc_ext();
    sc_reset();
    wrap_up();
  end
endmodule
bind rxc_checksum rxc_checksum_properties rxc_checksum_properties_i (.clk(clk), .srst(srst),
  .ce(ce), .rx(rx), .sts(sts), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

/* File: rxc_mac_model.sv */
// Receive MAC and FIFO controller model: streams bytes, captures status
`timescale 1ns/1ps
`default_nettype none
module rxc_mac_model (
  // Clock
  input wire logic clk,
  // Byte stream out, status in
  output rxc_pkg::rxc_byte_type rx,
  input wire rxc_pkg::rxc_sts_type sts
);
  logic [16:0] got;
  int cnt = 0;
  initial rx = '0;
  // One byte a cycle; idle data inverted so a stale byte never looks fresh
  task automatic send(input logic [7:0] b[$]);
    for (int i = 0; i < b.size(); i++) begin
      @(posedge clk);
      rx <= '{1'b1, i == 0, i == b.size() - 1, b[i]};
    end
    @(posedge clk);
    rx <= '{1'b0, 1'b0, 1'b0, ~rx.data};
  endtask
  // Latch each status pulse, as the FIFO controller would
  always @(posedge clk) begin
    if (sts.valid === 1'b1) begin
      got <= {sts.l4_err, sts.raw_sum};
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

/* File: rxc_params.svh */
// Constants for the receive ICMP/IGMP checksum checker
`ifndef RXC_PARAMS_SVH
`define RXC_PARAMS_SVH
`define RXC_CTRL_OFS 4'h0
`define RXC_STAT_OFS 4'h4
`define RXC_ICMP_EN_BIT 0
`define RXC_IGMP_EN_BIT 1
`define RXC_ERR_BIT 16
`define RXC_VLAN_TYPE 16'h8100
`define RXC_SNAP_LIMIT 16'h0600
`define RXC_ETH_IPV4 16'h0800
`define RXC_ETH_IPV6 16'h86dd
`define RXC_MAX_VLAN 2'h2
`define RXC_TYPE_HI_POS 16'h000c
`define RXC_TYPE_LO_POS 16'h000d
`define RXC_VLAN_REWIND 16'h000a
`define RXC_SNAP_REWIND 16'h0006
`define RXC_IP4_VERSION 4'h4
`define RXC_IP4_MIN_IHL 4'h5
`define RXC_IP4_TLEN_HI 16'h0002
`define RXC_IP4_TLEN_LO 16'h0003
`define RXC_IP4_FRAG_HI 16'h0006
`define RXC_IP4_FRAG_LO 16'h0007
`define RXC_IP4_PROTO 16'h0009
`define RXC_IP4_MF_BIT 5
`define RXC_IP6_PLEN_HI 16'h0004
`define RXC_IP6_PLEN_LO 16'h0005
`define RXC_IP6_NH 16'h0006
`define RXC_IP6_ADDR_FIRST 16'h0008
`define RXC_IP6_HDR_LAST 16'h0027
`define RXC_EXT_NH 16'h0000
`define RXC_EXT_LEN 16'h0001
`define RXC_PROTO_ICMP 8'h01
`define RXC_PROTO_IGMP 8'h02
`define RXC_PROTO_IPIP 8'h04
`define RXC_PROTO_IPV6 8'h29
`define RXC_PROTO_ICMPV6 8'h3a
`define RXC_NH_HOP 8'h00
`define RXC_NH_ROUTE 8'h2b
`define RXC_NH_FRAG 8'h2c
`define RXC_NH_DEST 8'h3c
`define RXC_SUM_OK 16'hffff
`endif

/* File: rxc_pkg.sv */
// Types shared by the receive ICMP/IGMP checksum checker
`default_nettype none
package rxc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_MAC, ST_IP4, ST_IP6, ST_EXT, ST_L4, ST_RAW} rxc_state_type;
  typedef enum logic [1:0] {K_NONE, K_ICMP4, K_ICMP6, K_IGMP} rxc_kind_type;
  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic [7:0] data;
  } rxc_byte_type;
  typedef struct packed {
    logic valid;
    logic l4_err;
    logic [15:0] raw_sum;
  } rxc_sts_type;
endpackage
`default_nettype wire
